// ==== bench/fwr_props.sv ====
// Port checker for the fault waveform recorder.
// Assumes it is bound to fwr_recorder and sees only its ports.
`timescale 1ns/1ns
module fwr_props
	import fwr_pkg::*;
(
	input wire logic          clk,                 // Clock.
	input wire logic          rst_n,               // Reset, active low.
	input wire logic          cfg_load,            // Load strobe.
	input wire fwr_cfg_s      cfg_in,              // New settings.
	input wire fwr_cfg_s      cfg_active,          // Settings in use.
	input wire logic [3:0]    rec_count,           // Records stored.
	input wire logic [MS_W:0] rec_total_ms,        // Stored length.
	input wire logic          capture_start_event, // Start pulse.
	input wire logic          recording_active     // Capture running.
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_len;
		cfg_load && cfg_in.max_len_ms inside {[MAXLEN_MIN:MAXLEN_MAX]} |=> cfg_active.max_len_ms == $past(cfg_in.max_len_ms);
	endproperty
	a_len: assert property (p_len) else $error("max length not taken");
	property p_pre;
		cfg_load && cfg_in.pre_ms inside {[PRE_MIN:PRE_MAX]} |=> cfg_active.pre_ms == $past(cfg_in.pre_ms);
	endproperty
	a_pre: assert property (p_pre) else $error("pre time not taken");
	property p_post;
		cfg_load && cfg_in.post_ms inside {[POST_MIN:POST_MAX]} |=> cfg_active.post_ms == $past(cfg_in.post_ms);
	endproperty
	a_post: assert property (p_post) else $error("post time not taken");
	property p_ext;
		cfg_load && cfg_in.external_trigger_capture_time inside {[EXT_MIN:EXT_MAX]}
			|=> cfg_active.external_trigger_capture_time == $past(cfg_in.external_trigger_capture_time);
	endproperty
	a_ext: assert property (p_ext) else $error("input capture time not taken");
	property p_mode;
		cfg_load && cfg_in.capture_trigger_mode == 2'b11 |=> cfg_active.capture_trigger_mode == FWR_SAVE_PICKUP;
	endproperty
	a_mode: assert property (p_mode) else $error("bad mode not mapped");
	property p_hold;
		!cfg_load |=> $stable(cfg_active);
	endproperty
	a_hold: assert property (p_hold) else $error("settings moved");
	property p_cnt;
		rec_count <= MAX_RECORDS && rec_total_ms <= TOTAL_LIMIT_MS;
	endproperty
	a_cnt: assert property (p_cnt) else $error("store over limit");
	property p_act;
		capture_start_event |-> recording_active ##1 !capture_start_event;
	endproperty
	a_act: assert property (p_act) else $error("active flag wrong");
endmodule : fwr_props

// ==== bench/fwr_reader.sv ====
// Reader model that fetches records from the recorder's output stream.
// Assumes rd_req starts each fetch; slow makes it stall in bursts.
`timescale 1ns/1ns
module fwr_reader
	import fwr_pkg::*;
(
	input wire logic      clk,       // Clock.
	input wire logic      rst_n,     // Reset, active low.
	input wire logic      rd_req,    // Fetch start.
	input wire logic      slow,      // Stall in bursts.
	input wire logic      out_valid, // Word offered.
	input wire fwr_out_s  out_data,  // Word.
	output logic          out_ready, // Word taken.
	output logic [15:0]   words,     // Words this fetch.
	output logic [1:0]    seen,      // Trip and pickup marks seen this fetch.
	output logic          done       // Last word seen.
);
	logic [5:0] tmr;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tmr <= '0;
			words <= '0;
			seen <= '0;
			done <= 1'b0;
			out_ready <= 1'b0;
		end else begin
			tmr <= tmr + 6'h1;
			out_ready <= !slow || tmr[5];
			if (rd_req) begin
				words <= '0;
				seen <= '0;
				done <= 1'b0;
			end else if (out_valid && out_ready) begin
				words <= words + 16'h1;
				seen <= seen | out_data.smp.marks[1:0];
				done <= out_data.last;
			end
		end
	end
endmodule : fwr_reader

// ==== bench/tb.sv ====
// Self-checking bench for the fault waveform recorder.
// Assumes a shortened tick so that whole records fit in the run.
`timescale 1ns/1ns
module tb;
	import fwr_pkg::*;
	localparam int TK = 4;
	logic clk = 0, rst_n = 0, pickup_pin = 0, trip_pin = 0, ext_trigger_pin = 0;
	logic serial_trigger = 0, sys_fault = 0, cfg_load = 0, rd_req = 0, slow = 0, sf_on = 0;
	logic [5:0]    marker_in = '0;
	logic [2:0]    rd_index = '0;
	fwr_smp_s      sample_in = '0;
	fwr_cfg_s      cfg_in = CFG_RESET;
	fwr_cfg_s      cfg_active;
	fwr_out_s      out_data;
	logic          out_valid, out_ready, rd_busy, rd_reject, recording_active;
	logic          capture_start_event, done, started, rejected;
	logic [3:0]    rec_count;
	logic [MS_W:0] rec_total_ms, base;
	logic [15:0]   words;
	logic [1:0]    seen;
	int            seed = 55040, n_fail = 0, checked = 0, cyc = 0;

	fwr_recorder #(.TICK_CNT(TK)) u_fwr_recorder (.clk, .rst_n, .pickup_pin, .trip_pin, .ext_trigger_pin,
		.serial_trigger, .sys_fault, .sample_in, .marker_in, .cfg_load, .cfg_in, .rd_req, .rd_index,
		.out_ready, .out_data, .out_valid, .rd_busy, .rd_reject, .recording_active, .capture_start_event,
		.rec_count, .rec_total_ms, .cfg_active);
	fwr_reader u_fwr_reader (.clk, .rst_n, .rd_req, .slow, .out_valid, .out_data, .out_ready, .words,
		.seen, .done);

	always #2 clk = ~clk;
	always @(negedge clk) begin
		for (int i = 0; i < NUM_CH; i++) sample_in.ch[i] <= 16'($random(seed));
		marker_in <= 6'($random(seed));
		sys_fault <= sf_on | 1'($random(seed));
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_fail = n_fail + 1;
			end_sim();
		end
	end

	function automatic logic [3:0] exp_cnt(input int k);
		return (k > 8) ? 4'h8 : 4'(k);
	endfunction : exp_cnt
	task automatic chk(input string nm, input logic [79:0] got, input logic [79:0] want);
		checked++;
		if (got !== want) begin
			n_fail++;
			$display("BAD %s expected %0h seen %0h", nm, want, got);
		end
	endtask : chk
	task automatic end_sim();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_sim
	task automatic load(input logic [2:0] m, input logic [15:0] mx, pr, po, ex);
		@(negedge clk);
		cfg_in = '{fwr_trig_e'(m[1:0]), fwr_scope_e'(m[2]), mx, pr, po, ex};
		cfg_load = 1;
		@(negedge clk);
		cfg_load = 0;
	endtask : load
	task automatic cap(input int src, input int hold);
		int n;
		@(negedge clk);
		case (src)
			0: serial_trigger = 1;
			1: ext_trigger_pin = 1;
			2: pickup_pin = 1;
			default: trip_pin = 1;
		endcase
		@(negedge clk);
		serial_trigger = 0;
		n = 0;
		while (!capture_start_event && n < 60) begin
			@(negedge clk);
			n++;
		end
		started = capture_start_event;
		repeat (hold * TK) @(negedge clk);
		{pickup_pin, trip_pin, ext_trigger_pin} = '0;
		n = 0;
		while (recording_active && n < 25000) begin
			@(negedge clk);
			n++;
		end
		repeat (20) @(negedge clk);
	endtask : cap
	task automatic rd(input logic [2:0] idx);
		int n;
		@(negedge clk);
		rd_req = 1;
		rd_index = idx;
		@(negedge clk);
		rd_req = 0;
		rejected = rd_reject;
		n = 0;
		while (!done && !rejected && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask : rd

	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1;
		@(negedge clk);
		chk("cfg reset", cfg_active, CFG_RESET);
		chk("count reset", rec_count, 0);
		load(3'b011, 0, 0, 0, 0);
		chk("clamp low", cfg_active, fwr_cfg_s'{FWR_SAVE_PICKUP, FWR_SCOPE_EVENT, MAXLEN_MIN, PRE_MIN, POST_MIN, EXT_MIN});
		load(3'b110, 16'hffff, 16'hffff, 16'hffff, 16'hffff);
		chk("clamp high", cfg_active, fwr_cfg_s'{FWR_START_TRIP, FWR_SCOPE_SYSTEM, MAXLEN_MAX, PRE_MAX, POST_MAX, EXT_MAX});
		$display("test settings done");
		load(3'b001, 300, 50, 50, 5000);
		cap(2, 10);
		chk("trip mode start", started, 1);
		chk("trip mode drop", rec_count, 0);
		load(3'b000, 300, 50, 50, 5000);
		cap(2, 10);
		chk("pickup keep", rec_count, 1);
		load(3'b010, 300, 50, 50, 5000);
		cap(2, 10);
		chk("start trip idle", started, 0);
		cap(3, 10);
		chk("start trip keep", rec_count, 2);
		rd(3'h1);
		chk("trip mark", seen[1], 1);
		chk("read idle", rd_busy, 0);
		rd(3'h5);
		chk("read refused", rejected, 1);
		load(3'b100, 300, 50, 50, 5000);
		sf_on = 1;
		base = rec_total_ms;
		cap(2, 10);
		sf_on = 0;
		chk("system scope", rec_total_ms - base, 300);
		$display("test modes done");
		load(3'b000, 300, 50, 50, 5000);
		for (int i = 0; i < 8; i++) begin
			cap(i % 2, 1);
			chk("count", rec_count, exp_cnt(i + 4));
		end
		chk("total", rec_total_ms, 8 * 300);
		slow = 1;
		rd(3'h0);
		chk("words slow", words, 300);
		slow = 0;
		rd(3'h7);
		chk("words", words, 300);
		$display("test store done");
		load(3'b000, 5000, 50, 50, 5000);
		cap(0, 1);
		chk("long total", rec_total_ms, 7 * 300 + 5000);
		chk("long count", rec_count, 8);
		$display("test long record done");
		end_sim();
	end
endmodule : tb

bind fwr_recorder fwr_props u_fwr_props (.clk, .rst_n, .cfg_load, .cfg_in, .cfg_active, .rec_count,
	.rec_total_ms, .capture_start_event, .recording_active);

// ==== hdl/fwr_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides and a registered head.
// Assumes one clock; a word is taken when valid and ready are both high.
`timescale 1ns/1ns
module fwr_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic             clk,       // System clock.
	input  wire logic             rst_n,     // Synchronous reset, active low.
	input  wire logic             in_valid,  // Word offered.
	output logic                  in_ready,  // Room for a word.
	input  wire logic [WIDTH-1:0] in_data,   // Word in.
	output logic                  out_valid, // Head word valid.
	input  wire logic             out_ready, // Sink takes head.
	output logic [WIDTH-1:0]      out_data   // Head word.
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	always_comb begin
		push     = in_valid && in_ready;
		pop      = (cnt_reg != '0) && (!out_valid || out_ready);
		wr_next  = push ? wr_reg + 1'b1 : wr_reg;
		rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
		cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	assign in_ready = (cnt_reg != DEPTH[AW:0]);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
		if (!rst_n) begin
			wr_reg    <= '0;
			rd_reg    <= '0;
			cnt_reg   <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
			if (pop) begin
				out_data  <= mem[rd_reg];
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end
endmodule : fwr_fifo

// ==== hdl/fwr_pkg.sv ====
// Shared constants, types and helpers for the fault waveform recorder.
// Assumes one 250 MHz clock; times are kept in milliseconds, one sample set each.
package fwr_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS    = 4;
	localparam int unsigned SAMPLE_PERIOD_NS = 1000000;
	localparam int unsigned TICK_CYCLES      = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned SYS_FREQ_HZ      = 50;
	localparam int unsigned SETS_PER_CYCLE   = 1000000000 / (SAMPLE_PERIOD_NS * SYS_FREQ_HZ);

	// ---------------------------------------------------------------
	// Sizes and limits
	// ---------------------------------------------------------------
	localparam int unsigned NUM_CH     = 10;
	localparam int unsigned CH_W       = 16;
	localparam int unsigned MARK_W     = 8;
	localparam int unsigned RING_AW    = 15;
	localparam int unsigned MS_W       = 16;
	localparam int unsigned FIFO_DEPTH = 32;
	localparam logic [3:0]  MAX_RECORDS       = 4'h8;
	localparam logic [MS_W-1:0] REC_LIMIT_MS  = 16'h1388;
	localparam logic [MS_W:0]   TOTAL_LIMIT_MS = 17'h061a8;

	// ---------------------------------------------------------------
	// Setting ranges and reset values, in ms
	// ---------------------------------------------------------------
	localparam logic [MS_W-1:0] MAXLEN_MIN = 16'h012c;
	localparam logic [MS_W-1:0] MAXLEN_MAX = REC_LIMIT_MS;
	localparam logic [MS_W-1:0] MAXLEN_DEF = 16'h07d0;
	localparam logic [MS_W-1:0] PRE_MIN    = 16'h0032;
	localparam logic [MS_W-1:0] PRE_MAX    = 16'h01f4;
	localparam logic [MS_W-1:0] PRE_DEF    = 16'h00fa;
	localparam logic [MS_W-1:0] POST_MIN   = 16'h0032;
	localparam logic [MS_W-1:0] POST_MAX   = 16'h01f4;
	localparam logic [MS_W-1:0] POST_DEF   = 16'h0064;
	localparam logic [MS_W-1:0] EXT_MIN    = 16'h0064;
	localparam logic [MS_W-1:0] EXT_MAX    = 16'h1388;
	localparam logic [MS_W-1:0] EXT_DEF    = 16'h01f4;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		FWR_SAVE_PICKUP = 2'b00,
		FWR_SAVE_TRIP   = 2'b01,
		FWR_START_TRIP  = 2'b10
	} fwr_trig_e;

	typedef enum logic {
		FWR_SCOPE_EVENT  = 1'b0,
		FWR_SCOPE_SYSTEM = 1'b1
	} fwr_scope_e;

	typedef struct packed {
		logic [NUM_CH-1:0][CH_W-1:0] ch;
		logic [MARK_W-1:0]           marks;
	} fwr_smp_s;

	typedef struct packed {
		fwr_trig_e       capture_trigger_mode;
		fwr_scope_e      scope;
		logic [MS_W-1:0] max_len_ms;
		logic [MS_W-1:0] pre_ms;
		logic [MS_W-1:0] post_ms;
		logic [MS_W-1:0] external_trigger_capture_time;
	} fwr_cfg_s;

	typedef struct packed {
		fwr_smp_s smp;
		logic     last;
	} fwr_out_s;

	localparam fwr_cfg_s CFG_RESET = '{FWR_SAVE_PICKUP, FWR_SCOPE_EVENT, MAXLEN_DEF, PRE_DEF, POST_DEF, EXT_DEF};

	function automatic logic [MS_W-1:0] fwr_clamp(input logic [MS_W-1:0] v, input logic [MS_W-1:0] lo,
		input logic [MS_W-1:0] hi);
		fwr_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : fwr_clamp

endpackage : fwr_pkg

// ==== hdl/fwr_recorder.sv ====
// Fault waveform recorder: ring of sample sets, capture control, record store and readout.
// Assumes fault pins are asynchronous, sample data and commands come from logic on clk.
// What this block does
// (R1) Take one sample set of every channel on each 1 ms tick.
// (R2) Write samples continuously into a ring, overwriting oldest data.
// (R3) Stop a capture at its set length, never longer than five seconds.
// (R4) Keep at most eight records at once.
// (R5) Accept every new fault without acknowledgement of older records.
// (R6) Start capture on pickup, external trigger input, or serial command.
// (R7) A record is pre-trigger, recording span, then post time after criterion drops.
// (R8) Total length of all stored records stays within twenty-five seconds.
// (R9) Maximum record length 0.30 to 5.00 s, reset value 2.00 s.
// (R10) Pre-trigger time 0.05 to 0.50 s, reset value 0.25 s.
// (R11) Post-trigger time 0.05 to 0.50 s, reset value 0.10 s.
// (R12) External trigger captures last 0.10 to 5.00 s, reset value 0.50 s.
// (R13) Scope selects single fault event or whole power system fault.
// (R14) Store pickup, trip and other markers with each sample set.
// (R15) Drive recording-active while a capture runs.
// (R16) The controller fetches records itself after pickup or trip; this block only reads a record out when rd_req asks for it.
// (R17) Drop oldest records first when count or total limit would be passed.
// (R18) Trigger mode: save on pickup, save on trip, or start at trip.
`timescale 1ns/1ns
module fwr_recorder
	import fwr_pkg::*;
#(
	parameter int unsigned TICK_CNT = TICK_CYCLES
) (
	input  wire logic              clk,              // System clock, 250 MHz.
	input  wire logic              rst_n,            // Synchronous reset, active low.
	input  wire logic              pickup_pin,       // Protection pickup, asynchronous.
	input  wire logic              trip_pin,         // Protection trip, asynchronous.
	input  wire logic              ext_trigger_pin,  // External trigger input, asynchronous.
	input  wire logic              serial_trigger,   // Serial trigger command, one-cycle pulse.
	input  wire logic              sys_fault,        // Power system fault in progress.
	input  wire fwr_smp_s          sample_in,        // Channel values, marks field ignored.
	input  wire logic [MARK_W-3:0] marker_in,        // Extra internal signals to mark.
	input  wire logic              cfg_load,         // Load cfg_in, one-cycle pulse.
	input  wire fwr_cfg_s          cfg_in,           // New settings.
	input  wire logic              rd_req,           // Read request, one-cycle pulse.
	input  wire logic [2:0]        rd_index,         // Record to read, 0 is the oldest.
	input  wire logic              out_ready,        // Reader takes a sample set.
	output fwr_out_s               out_data,         // Sample set being read out.
	output logic                   out_valid,        // out_data is valid.
	output logic                   rd_busy,          // Readout in progress.
	output logic                   rd_reject,        // Request refused, one-cycle pulse.
	output logic                   recording_active, // Capture in progress.
	output logic                   capture_start_event, // Capture started, one-cycle pulse.
	output logic [3:0]             rec_count,        // Records stored.
	output logic [MS_W:0]          rec_total_ms,     // Total stored length in ms.
	output fwr_cfg_s               cfg_active        // Settings in use.
);
	typedef enum logic [1:0] {FWR_CAP_IDLE = 2'b00, FWR_CAP_RUN = 2'b01, FWR_CAP_POST = 2'b10} fwr_cap_e;
	typedef enum logic {FWR_ST_IDLE = 1'b0, FWR_ST_PRUNE = 1'b1} fwr_st_e;

	// ---------------------------------------------------------------
	// Input synchronisers, settings and sampling tick
	// ---------------------------------------------------------------
	logic [2:0] sync1_reg, sync2_reg, prev_reg;
	logic       pick_s, trip_s, ext_s, tick;
	fwr_cfg_s   cfg_reg, cfg_next;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1_reg <= 3'h0;
			sync2_reg <= 3'h0;
			prev_reg  <= 3'h0;
		end else begin
			sync1_reg <= {ext_trigger_pin, trip_pin, pickup_pin};
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end
	assign pick_s = sync2_reg[0];
	assign trip_s = sync2_reg[1];
	assign ext_s  = sync2_reg[2];

	always_comb begin
		cfg_next = cfg_reg;
		if (cfg_load) begin
			cfg_next.capture_trigger_mode = (cfg_in.capture_trigger_mode == 2'b11) ?
				FWR_SAVE_PICKUP : cfg_in.capture_trigger_mode; // R18
			cfg_next.scope      = cfg_in.scope; // R13
			cfg_next.max_len_ms = fwr_clamp(cfg_in.max_len_ms, MAXLEN_MIN, MAXLEN_MAX); // R9
			cfg_next.pre_ms     = fwr_clamp(cfg_in.pre_ms, PRE_MIN, PRE_MAX); // R10
			cfg_next.post_ms    = fwr_clamp(cfg_in.post_ms, POST_MIN, POST_MAX); // R11
			cfg_next.external_trigger_capture_time =
				fwr_clamp(cfg_in.external_trigger_capture_time, EXT_MIN, EXT_MAX); // R12
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_reg <= CFG_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	fwr_tick_div #(.CYCLES(TICK_CNT)) u_tick (
		.clk   (clk),
		.rst_n (rst_n),
		.tick  (tick)
	);

	// ---------------------------------------------------------------
	// Sample ring
	// ---------------------------------------------------------------
	fwr_smp_s           ring [2**RING_AW];
	fwr_smp_s           ring_q;
	logic [RING_AW-1:0] wp_reg, raddr_reg;
	logic               rd_issue;

	always_ff @(posedge clk) begin
		if (tick) begin
			ring[wp_reg] <= '{ch: sample_in.ch, marks: {marker_in, trip_s, pick_s}}; // R1 R2 R14
		end
		if (rd_issue) begin
			ring_q <= ring[raddr_reg];
		end
		if (!rst_n) begin
			wp_reg <= '0;
		end else if (tick) begin
			wp_reg <= wp_reg + 1'b1; // R2
		end
	end

	// ---------------------------------------------------------------
	// Capture control
	// ---------------------------------------------------------------
	fwr_cap_e           cap_reg, cap_next;
	logic               pend_f_reg, pend_f_next, pend_e_reg, pend_e_next;
	logic               extc_reg, extc_next, tseen_reg, tseen_next;
	logic [RING_AW-1:0] cstart_reg, cstart_next;
	logic [MS_W-1:0]    clen_reg, clen_next, ecnt_reg, ecnt_next, pcnt_reg, pcnt_next, len_inc;
	logic               crit, fault_rise, commit, start_ev;

	always_comb begin
		cap_next    = cap_reg;
		cstart_next = cstart_reg;
		clen_next   = clen_reg;
		ecnt_next   = ecnt_reg;
		pcnt_next   = pcnt_reg;
		extc_next   = extc_reg;
		tseen_next  = tseen_reg;
		commit      = 1'b0;
		start_ev    = 1'b0;
		len_inc     = clen_reg + 16'h1;
		fault_rise  = (cfg_reg.capture_trigger_mode == FWR_START_TRIP) ?
			(trip_s && !prev_reg[1]) : (pick_s && !prev_reg[0]); // R18
		crit = extc_reg ? (ecnt_reg < cfg_reg.external_trigger_capture_time) : // R12
			(((cfg_reg.capture_trigger_mode == FWR_START_TRIP) ? trip_s : pick_s) ||
			 (cfg_reg.scope == FWR_SCOPE_SYSTEM && sys_fault)); // R13
		pend_f_next = pend_f_reg || fault_rise; // R6
		pend_e_next = pend_e_reg || (ext_s && !prev_reg[2]) || serial_trigger; // R6
		if (tick) begin
			unique case (cap_reg)
				FWR_CAP_IDLE: begin
					if (pend_f_reg || pend_e_reg) begin
						cap_next    = FWR_CAP_RUN;
						cstart_next = wp_reg - cfg_reg.pre_ms[RING_AW-1:0]; // R7
						clen_next   = cfg_reg.pre_ms + 16'h1;
						extc_next   = !pend_f_reg;
						ecnt_next   = 16'h1;
						tseen_next  = trip_s;
						start_ev    = 1'b1;
						pend_f_next = 1'b0;
						pend_e_next = 1'b0;
					end
				end
				FWR_CAP_RUN, FWR_CAP_POST: begin
					clen_next   = len_inc;
					ecnt_next   = ecnt_reg + 16'h1;
					tseen_next  = tseen_reg || trip_s;
					pend_f_next = 1'b0;
					pend_e_next = 1'b0;
					if (cap_reg == FWR_CAP_RUN && !crit) begin
						cap_next  = FWR_CAP_POST; // R7
						pcnt_next = 16'h1;
					end else if (cap_reg == FWR_CAP_POST) begin
						pcnt_next = pcnt_reg + 16'h1;
						if (crit) begin
							cap_next = FWR_CAP_RUN;
						end else if (pcnt_next >= cfg_reg.post_ms) begin
							commit = 1'b1; // R7
						end
					end
					if (len_inc >= cfg_reg.max_len_ms || len_inc >= REC_LIMIT_MS) begin
						commit = 1'b1; // R3
					end
					if (commit) begin
						cap_next = FWR_CAP_IDLE;
					end
				end
				default: begin
					cap_next = FWR_CAP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_reg             <= FWR_CAP_IDLE;
			pend_f_reg          <= 1'b0;
			pend_e_reg          <= 1'b0;
			extc_reg            <= 1'b0;
			tseen_reg           <= 1'b0;
			cstart_reg          <= '0;
			clen_reg            <= '0;
			ecnt_reg            <= '0;
			pcnt_reg            <= '0;
			recording_active    <= 1'b0;
			capture_start_event <= 1'b0;
		end else begin
			cap_reg             <= cap_next;
			pend_f_reg          <= pend_f_next;
			pend_e_reg          <= pend_e_next;
			extc_reg            <= extc_next;
			tseen_reg           <= tseen_next;
			cstart_reg          <= cstart_next;
			clen_reg            <= clen_next;
			ecnt_reg            <= ecnt_next;
			pcnt_reg            <= pcnt_next;
			recording_active    <= (cap_next != FWR_CAP_IDLE); // R15
			capture_start_event <= start_ev;
		end
	end

	// ---------------------------------------------------------------
	// Record store
	// ---------------------------------------------------------------
	logic [RING_AW-1:0] slot_start [8];
	logic [MS_W-1:0]    slot_len [8];
	fwr_st_e            st_reg, st_next;
	logic [2:0]         head_reg, head_next;
	logic [3:0]         cnt_next;
	logic [MS_W:0]      total_next;
	logic [RING_AW-1:0] nstart_reg, nstart_next;
	logic [MS_W-1:0]    nlen_reg, nlen_next;
	logic               drop, wr_slot, keep;

	// A record is also dropped once the ring is about to overwrite its first sample set.
	always_comb begin
		st_next     = st_reg;
		head_next   = head_reg;
		cnt_next    = rec_count;
		total_next  = rec_total_ms;
		nstart_next = nstart_reg;
		nlen_next   = nlen_reg;
		wr_slot     = 1'b0;
		keep        = (cfg_reg.capture_trigger_mode != FWR_SAVE_TRIP) || extc_reg || tseen_next; // R18
		drop        = (rec_count != 4'h0) && ((tick && slot_start[head_reg] == wp_reg) || // R2
			(st_reg == FWR_ST_PRUNE && (rec_count == MAX_RECORDS || // R4 R17
			 rec_total_ms + {1'b0, nlen_reg} > TOTAL_LIMIT_MS))); // R8 R17
		if (drop) begin
			head_next  = head_reg + 3'h1;
			cnt_next   = rec_count - 4'h1;
			total_next = rec_total_ms - {1'b0, slot_len[head_reg]};
		end else if (st_reg == FWR_ST_PRUNE) begin
			wr_slot    = 1'b1; // R5
			cnt_next   = rec_count + 4'h1;
			total_next = rec_total_ms + {1'b0, nlen_reg};
			st_next    = FWR_ST_IDLE;
		end
		if (commit && keep) begin
			st_next     = FWR_ST_PRUNE;
			nstart_next = cstart_reg;
			nlen_next   = len_inc;
		end
	end

	always_ff @(posedge clk) begin
		if (wr_slot) begin
			slot_start[head_reg + rec_count[2:0]] <= nstart_reg;
			slot_len[head_reg + rec_count[2:0]]   <= nlen_reg;
		end
		if (!rst_n) begin
			st_reg       <= FWR_ST_IDLE;
			head_reg     <= 3'h0;
			rec_count    <= 4'h0;
			rec_total_ms <= '0;
			nstart_reg   <= '0;
			nlen_reg     <= '0;
		end else begin
			st_reg       <= st_next;
			head_reg     <= head_next;
			rec_count    <= cnt_next;
			rec_total_ms <= total_next;
			nstart_reg   <= nstart_next;
			nlen_reg     <= nlen_next;
		end
	end

	assign cfg_active = cfg_reg;

	// ---------------------------------------------------------------
	// Readout through the FIFO
	// ---------------------------------------------------------------
	logic               rd_busy_next, rej_next, push_reg, last_reg, f_ready;
	logic [RING_AW-1:0] raddr_next;
	logic [MS_W-1:0]    remain_reg, remain_next;
	logic [2:0]         rslot;

	always_comb begin
		rd_busy_next = rd_busy;
		raddr_next   = raddr_reg;
		remain_next  = remain_reg;
		rej_next     = 1'b0;
		rd_issue     = 1'b0;
		rslot        = head_reg + rd_index;
		if (rd_req) begin
			if (rd_busy || {1'b0, rd_index} >= rec_count) begin
				rej_next = 1'b1;
			end else begin
				rd_busy_next = 1'b1;
				raddr_next   = slot_start[rslot];
				remain_next  = slot_len[rslot];
			end
		end else if (rd_busy && f_ready && !push_reg) begin
			rd_issue    = 1'b1;
			raddr_next  = raddr_reg + 1'b1;
			remain_next = remain_reg - 16'h1;
			if (remain_reg == 16'h1) begin
				rd_busy_next = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_busy    <= 1'b0;
			rd_reject  <= 1'b0;
			raddr_reg  <= '0;
			remain_reg <= '0;
			push_reg   <= 1'b0;
			last_reg   <= 1'b0;
		end else begin
			rd_busy    <= rd_busy_next;
			rd_reject  <= rej_next;
			raddr_reg  <= raddr_next;
			remain_reg <= remain_next;
			push_reg   <= rd_issue;
			last_reg   <= rd_issue && (remain_reg == 16'h1);
		end
	end

	fwr_fifo #(.WIDTH($bits(fwr_out_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (push_reg),
		.in_ready  (f_ready),
		.in_data   ({ring_q, last_reg}),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (out_data)
	);
endmodule : fwr_recorder

// ==== hdl/fwr_tick_div.sv ====
// Divider that turns the system clock into the one-cycle sampling tick.
// Assumes clk and a synchronous active-low reset.
`timescale 1ns/1ns
module fwr_tick_div #(
	parameter int unsigned CYCLES = 250000
) (
	input  wire logic clk,   // System clock.
	input  wire logic rst_n, // Synchronous reset, active low.
	output logic      tick   // One-cycle pulse every CYCLES clocks.
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic        tick_next;

	always_comb begin
		tick_next = (cnt_reg == CYCLES - 1);
		cnt_next  = tick_next ? 32'h0 : cnt_reg + 32'h1;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= 32'h0;
			tick    <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick    <= tick_next;
		end
	end
endmodule : fwr_tick_div
